// [hdl/tcr_pkg.sv]
/*
 * constants, register map and helpers for the timer control block.
 * assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package tcr_pkg;
    localparam int AXI_AW = 12;
    // register byte offsets
    localparam logic [AXI_AW-1:0] OFF_CFG = 12'h000;
    localparam logic [AXI_AW-1:0] OFF_CTL = 12'h00c;
    localparam logic [AXI_AW-1:0] OFF_LOAD_A = 12'h028;
    localparam logic [AXI_AW-1:0] OFF_LOAD_B = 12'h02c;
    localparam logic [AXI_AW-1:0] OFF_CNT_A = 12'h048;
    localparam logic [AXI_AW-1:0] OFF_CNT_B = 12'h04c;
    localparam logic [AXI_AW-1:0] OFF_RTC = 12'h050;
    localparam logic [AXI_AW-1:0] OFF_EVT_A = 12'h060;
    localparam logic [AXI_AW-1:0] OFF_EVT_B = 12'h064;
    // control field positions
    localparam int CTL_A_EN = 0;
    localparam int CTL_A_FRZ = 1;
    localparam int CTL_A_EDGE = 2;
    localparam int CTL_CAL_EN = 4;
    localparam int CTL_A_TRIG = 5;
    localparam int CTL_A_INV = 6;
    localparam int CTL_B_EN = 8;
    localparam int CTL_B_FRZ = 9;
    localparam int CTL_B_EDGE = 10;
    localparam logic [31:0] CTL_MASK = 32'h0000_0f7f;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam logic [31:0] LOAD_RESET = 32'hffff_ffff;
    localparam logic [31:0] HALF16_MASK = 32'h0000_ffff;
    // arrangement codes; bit 2 set means two 16-bit halves
    localparam logic [2:0] CFG_T32 = 3'h0;
    localparam logic [2:0] CFG_CAL = 3'h1;
    localparam int CFG_SPLIT_BIT = 2;
    // capture edge codes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RSVD = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // true when the selected edge is seen between two samples
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        case (sel)
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            EDGE_BOTH: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // merge write data into a word under byte strobes
    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge_bytes = r;
    endfunction : merge_bytes
endpackage : tcr_pkg

// [hdl/tcr_half_if.sv]
/*
 * control and status bundle between the register file and one timer half.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface tcr_half_if;
    logic enable;
    logic freeze;
    logic halted;
    logic pin;
    logic [1:0] edge_sel;
    logic [31:0] load;
    logic [31:0] count;
    logic [15:0] events;
    logic timeout;
    modport ctl (output enable, freeze, halted, pin, edge_sel, load,
                 input count, events, timeout);
    modport half (input enable, freeze, halted, pin, edge_sel, load,
                  output count, events, timeout);
endinterface : tcr_half_if

// [hdl/tcr_sync.sv]
/*
 * two-flop synchroniser for a group of independent levels.
 * assumes each bit is a slow level from outside the clock domain.
 */
`timescale 1ns/1ps
module tcr_sync #(
    parameter int W = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } tcr_sync_t;
    tcr_sync_t s_reg;
    tcr_sync_t s_next;

    // first stage feeds only the second
    always_comb begin
        s_next = s_reg;
        if (ce) begin
            s_next.meta = d;
            s_next.stab = s_reg.meta;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stab;
endmodule : tcr_sync

// [hdl/tcr_half.sv]
/*
 * one timer half: down counter with reload, debug freeze and edge counter.
 * assumes pin and halted are already synchronised to aclk.
 */
`timescale 1ns/1ps
module tcr_half (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    tcr_half_if.half hif
);
    import tcr_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic [15:0] evt;
        logic pin_q;
        logic tout;
    } tcr_half_t;
    tcr_half_t s_reg;
    tcr_half_t s_next;
    logic run;

    // frozen only while the debugger halts and freeze is set
    assign run = hif.enable & ~(hif.halted & hif.freeze);

    always_comb begin
        s_next = s_reg;
        if (ce) begin
            s_next.tout = 1'b0;
            s_next.pin_q = hif.pin;
            if (!hif.enable) begin
                s_next.cnt = hif.load;
            end else if (run) begin
                if (s_reg.cnt == '0) begin
                    s_next.cnt = hif.load;
                    s_next.tout = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt - 32'h0000_0001;
                end
            end
            // capture logic counts selected edges while running
            if (run && edge_hit(hif.edge_sel, s_reg.pin_q, hif.pin)) begin
                s_next.evt = s_reg.evt + 16'h0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hif.count = s_reg.cnt;
    assign hif.events = s_reg.evt;
    assign hif.timeout = s_reg.tout;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_edge_rsvd;
        (ce && hif.edge_sel == EDGE_RSVD) |=> $stable(s_reg.evt);
    endproperty
    a_edge_rsvd: assert property (p_edge_rsvd) else $error("reserved edge code counted");

    property p_edge_rise;
        (ce && run && hif.edge_sel == EDGE_RISE && hif.pin && !s_reg.pin_q)
            |=> s_reg.evt == $past(s_reg.evt) + 16'h0001;
    endproperty
    a_edge_rise: assert property (p_edge_rise) else $error("rising edge missed");

    property p_edge_both;
        (ce && run && hif.edge_sel == EDGE_BOTH && (hif.pin != s_reg.pin_q))
            |=> s_reg.evt != $past(s_reg.evt);
    endproperty
    a_edge_both: assert property (p_edge_both) else $error("edge missed in both mode");

    property p_freeze;
        (ce && hif.enable && hif.halted && hif.freeze) |=> $stable(s_reg.cnt);
    endproperty
    a_freeze: assert property (p_freeze) else $error("counter moved while frozen");

    property p_run_halted;
        (ce && hif.enable && hif.halted && !hif.freeze && s_reg.cnt != '0)
            |=> s_reg.cnt == $past(s_reg.cnt) - 32'h0000_0001;
    endproperty
    a_run_halted: assert property (p_run_halted) else $error("counter stopped without freeze");

    property p_disabled;
        (ce && !hif.enable) |=> (s_reg.cnt == $past(hif.load)) && !s_reg.tout;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled half not held at load");
endmodule : tcr_half

// [hdl/tcr_top.sv]
/*
 * timer control register block with AXI4-Lite slave, two timer halves,
 * calendar counter, inverted pwm output and converter trigger pulse.
 * assumes a single 200 MHz clock, debug halt and capture pins asynchronous.
 */
`timescale 1ns/1ps
module tcr_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [tcr_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [tcr_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic debug_halt,
    input wire logic capture_a_pin,
    input wire logic capture_b_pin,
    output logic pwm_a,
    output logic converter_trigger
);
    import tcr_pkg::*;

    typedef struct packed {
        logic [2:0] cfg;
        logic [31:0] ctl;
        logic [31:0] load_a;
        logic [31:0] load_b;
        logic [31:0] rtc;
        logic aw_got;
        logic w_got;
        logic [AXI_AW-1:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic pwm_raw;
        logic pwm;
        logic trig;
    } tcr_top_t;
    tcr_top_t s_reg;
    tcr_top_t s_next;

    logic [2:0] sync_q;
    logic split;
    logic cal_mode;
    logic [31:0] cfg_merged;

    tcr_half_if a_if ();
    tcr_half_if b_if ();

    // debug halt and capture pins cross into aclk
    tcr_sync #(
        .W(3)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .d({debug_halt, capture_b_pin, capture_a_pin}),
        .q(sync_q)
    );

    // arrangement decode steers the halves
    assign split = s_reg.cfg[CFG_SPLIT_BIT];
    assign cal_mode = (s_reg.cfg == CFG_CAL);
    // cfg write merged as a full word, only the low field is kept
    assign cfg_merged = merge_bytes({29'h0, s_reg.cfg}, s_reg.wd, s_reg.ws);

    // half a runs alone as 32-bit timer or as a 16-bit half
    assign a_if.enable = s_reg.ctl[CTL_A_EN] & (split | (s_reg.cfg == CFG_T32));
    assign a_if.freeze = s_reg.ctl[CTL_A_FRZ];
    assign a_if.halted = sync_q[2];
    assign a_if.pin = sync_q[0];
    assign a_if.edge_sel = s_reg.ctl[CTL_A_EDGE +: 2];
    assign a_if.load = split ? (s_reg.load_a & HALF16_MASK) : s_reg.load_a;

    // half b only exists in the split arrangements
    assign b_if.enable = s_reg.ctl[CTL_B_EN] & split;
    assign b_if.freeze = s_reg.ctl[CTL_B_FRZ];
    assign b_if.halted = sync_q[2];
    assign b_if.pin = sync_q[1];
    assign b_if.edge_sel = s_reg.ctl[CTL_B_EDGE +: 2];
    assign b_if.load = s_reg.load_b & HALF16_MASK;

    tcr_half u_half_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .hif(a_if)
    );

    tcr_half u_half_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .hif(b_if)
    );

    // bus slave, register writes, calendar counter and outputs
    always_comb begin
        s_next = s_reg;
        if (ce) begin
            // write address and data are taken in either order
            if (s_reg.awready && awvalid) begin
                s_next.aw_got = 1'b1;
                s_next.wa = awaddr;
            end
            if (s_reg.wready && wvalid) begin
                s_next.w_got = 1'b1;
                s_next.wd = wdata;
                s_next.ws = wstrb;
            end
            if (s_reg.bvalid && bready) begin
                s_next.bvalid = 1'b0;
            end
            // calendar counts only in its own arrangement
            if (cal_mode && s_reg.ctl[CTL_CAL_EN]) begin
                s_next.rtc = s_reg.rtc + 32'h0000_0001;
            end
            // both halves of a write held: commit and answer
            if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
                s_next.aw_got = 1'b0;
                s_next.w_got = 1'b0;
                s_next.bvalid = 1'b1;
                s_next.bresp = RESP_OKAY;
                case (s_reg.wa)
                    OFF_CFG: begin
                        s_next.cfg = cfg_merged[2:0];
                    end
                    OFF_CTL: begin
                        s_next.ctl = merge_bytes(s_reg.ctl, s_reg.wd, s_reg.ws) & CTL_MASK;
                    end
                    OFF_LOAD_A: begin
                        s_next.load_a = merge_bytes(s_reg.load_a, s_reg.wd, s_reg.ws);
                    end
                    OFF_LOAD_B: begin
                        s_next.load_b = merge_bytes(s_reg.load_b, s_reg.wd, s_reg.ws);
                    end
                    OFF_CNT_A, OFF_CNT_B, OFF_RTC, OFF_EVT_A, OFF_EVT_B: begin
                        s_next.bresp = RESP_OKAY; // read-only, write ignored
                    end
                    default: begin
                        s_next.bresp = RESP_SLVERR;
                    end
                endcase
            end
            // read channel answers one cycle after the address
            if (s_reg.rvalid && rready) begin
                s_next.rvalid = 1'b0;
            end
            if (s_reg.arready && arvalid) begin
                s_next.rvalid = 1'b1;
                s_next.rresp = RESP_OKAY;
                case (araddr)
                    OFF_CFG: s_next.rdata = {29'h0, s_reg.cfg};
                    OFF_CTL: s_next.rdata = s_reg.ctl;
                    OFF_LOAD_A: s_next.rdata = s_reg.load_a;
                    OFF_LOAD_B: s_next.rdata = s_reg.load_b;
                    OFF_CNT_A: s_next.rdata = a_if.count;
                    OFF_CNT_B: s_next.rdata = b_if.count;
                    OFF_RTC: s_next.rdata = s_reg.rtc;
                    OFF_EVT_A: s_next.rdata = {16'h0, a_if.events};
                    OFF_EVT_B: s_next.rdata = {16'h0, b_if.events};
                    default: begin
                        s_next.rdata = 32'h0000_0000;
                        s_next.rresp = RESP_SLVERR;
                    end
                endcase
            end
            // raw pwm toggles on each half a time-out
            if (a_if.timeout) begin
                s_next.pwm_raw = ~s_reg.pwm_raw;
            end
            s_next.pwm = s_next.pwm_raw ^ s_reg.ctl[CTL_A_INV];
            // trigger pulse follows a time-out while enabled
            s_next.trig = a_if.timeout & s_reg.ctl[CTL_A_TRIG];
            // ready flags follow what is still held
            s_next.awready = ~s_next.aw_got & ~s_next.bvalid;
            s_next.wready = ~s_next.w_got & ~s_next.bvalid;
            s_next.arready = ~s_next.rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.cfg <= CFG_RESET;
            s_reg.ctl <= CTL_RESET;
            s_reg.load_a <= LOAD_RESET;
            s_reg.load_b <= LOAD_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // every output straight from the state flops
    assign awready = s_reg.awready;
    assign wready = s_reg.wready;
    assign bvalid = s_reg.bvalid;
    assign bresp = s_reg.bresp;
    assign arready = s_reg.arready;
    assign rvalid = s_reg.rvalid;
    assign rresp = s_reg.rresp;
    assign rdata = s_reg.rdata;
    assign pwm_a = s_reg.pwm;
    assign converter_trigger = s_reg.trig;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_trig_gate;
        (ce && !s_reg.ctl[CTL_A_TRIG]) |=> !converter_trigger;
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("trigger while disabled");

    property p_trig_pulse;
        (ce && a_if.timeout && s_reg.ctl[CTL_A_TRIG]) |=> converter_trigger;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("time-out gave no trigger");

    property p_trig_cause;
        (ce && !a_if.timeout) |=> !converter_trigger;
    endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("trigger without time-out");

    property p_pwm_inv;
        ce |=> pwm_a == (s_reg.pwm_raw ^ $past(s_reg.ctl[CTL_A_INV]));
    endproperty
    a_pwm_inv: assert property (p_pwm_inv) else $error("pwm polarity wrong");

    property p_cal_count;
        (ce && cal_mode && s_reg.ctl[CTL_CAL_EN]) |=> s_reg.rtc == $past(s_reg.rtc) + 32'h1;
    endproperty
    a_cal_count: assert property (p_cal_count) else $error("calendar did not count");

    property p_cal_hold;
        (ce && !(cal_mode && s_reg.ctl[CTL_CAL_EN])) |=> $stable(s_reg.rtc);
    endproperty
    a_cal_hold: assert property (p_cal_hold) else $error("calendar counted while off");

    property p_arrange;
        cal_mode |-> !a_if.enable && !b_if.enable;
    endproperty
    a_arrange: assert property (p_arrange) else $error("half active in calendar mode");

    property p_b_split;
        (!split && s_reg.ctl[CTL_B_EN]) |-> !b_if.enable;
    endproperty
    a_b_split: assert property (p_b_split) else $error("half b active outside split");

    property p_a_enable;
        (s_reg.ctl[CTL_A_EN] && (s_reg.cfg == CFG_T32)) |-> a_if.enable;
    endproperty
    a_a_enable: assert property (p_a_enable) else $error("half a not enabled");

    property p_bresp_hold;
        (bvalid && !bready) |=> bvalid && $stable(bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

    property p_rdata_hold;
        (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");

    property p_write_busy;
        bvalid |-> !awready && !wready;
    endproperty
    a_write_busy: assert property (p_write_busy) else $error("write taken during response");

    property p_ce_hold;
        !ce |=> $stable(s_reg) && $stable(a_if.count) && $stable(b_if.count);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("state moved with clock enable low");
endmodule : tcr_top

// [sim/tcr_conv_model.sv]
/*
 * far-side model: converter trigger input and debugger halt source.
 * assumes the trigger is a one-cycle pulse on aclk.
 */
`timescale 1ns/1ps
module tcr_conv_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic converter_trigger,
    input wire logic conv_on,
    input wire logic src_sel,
    input wire logic halt_req,
    output logic debug_halt,
    output logic [31:0] starts
);
    // halt level straight from the bench
    assign debug_halt = halt_req;

    // a conversion starts only when enabled and this timer is the source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            starts <= 32'h0;
        end else if (converter_trigger && conv_on && src_sel) begin
            starts <= starts + 32'h1;
        end
    end
endmodule : tcr_conv_model

// [sim/tb_timer_control_register.sv]
/*
 * bench for the timer control block: register rows, trigger, pwm, freeze, edges.
 * assumes tcr_top, tcr_pkg and the converter model.
 */
`timescale 1ns/1ps
module tb_timer_control_register;
    import tcr_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, pwm_a, converter_trigger, debug_halt;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, v, w, starts, s0, e_a, e_b;
    logic cap_a = 1'b0, cap_b = 1'b0, halt_req = 1'b0, conv_on = 1'b1, src_sel = 1'b1, p;
    logic ce = 1'b1;
    int miscompares = 0, check_count = 0, pulses, dbl;
    logic [11:0] ra [6] = '{OFF_CTL, OFF_CTL, OFF_CFG, OFF_CFG, 12'h100, OFF_LOAD_B};
    logic [31:0] rw [6] = '{32'hffff_ffff, 32'h0, 32'hffff_ffff, 32'h4, 32'h1234, 32'habcd};
    logic [31:0] rx [6] = '{32'hf7f, 32'h0, 32'h7, 32'h4, 32'h0, 32'habcd};
    logic [1:0] rr [6] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR, RESP_OKAY};
    logic [31:0] dexp [4] = '{32'h1, 32'h1, 32'h0, 32'h2};

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    tcr_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .debug_halt(debug_halt),
        .capture_a_pin(cap_a), .capture_b_pin(cap_b), .pwm_a(pwm_a),
        .converter_trigger(converter_trigger));

    tcr_conv_model conv (.aclk(aclk), .aresetn(aresetn), .converter_trigger(converter_trigger),
        .conv_on(conv_on), .src_sel(src_sel), .halt_req(halt_req),
        .debug_halt(debug_halt), .starts(starts));

    // verdict and end of run
    task automatic summarize;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask : chk

    // a wait that ran out ends the run
    task automatic bail(input int i);
        if (i >= 100) begin
            miscompares++;
            $display("wait ran out");
            summarize();
        end
    endtask : bail

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    // bus write, each channel released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            i++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && i < 100);
        r = bresp;
        bready <= 1'b0;
        bail(i);
    endtask : wr

    // bus read into v and r
    task automatic rd(input logic [11:0] a);
        int i;
        i = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            i++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && i < 100);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        bail(i);
    endtask : rd

    // count trigger pulses and back-to-back highs
    task automatic measure(input int n);
        logic prev;
        prev = 1'b0;
        pulses = 0;
        dbl = 0;
        cyc(8); // let a fresh setting reach the pin first
        s0 = starts;
        // sample the value the converter model sees at the same edge
        repeat (n) begin
            if (converter_trigger === 1'b1) begin
                pulses++;
                if (prev) dbl++;
            end
            prev = (converter_trigger === 1'b1);
            @(posedge aclk);
        end
    endtask : measure

    // two reads apart, equal or not
    task automatic same_twice(input logic [11:0] a, input logic s, input string n);
        rd(a);
        w = v;
        cyc(3);
        rd(a);
        chk(n, {31'h0, s}, {31'h0, v === w});
    endtask : same_twice

    // main sequence
    initial begin
        cyc(3);
        aresetn <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            wr(ra[k], rw[k]);
            chk("bresp", {30'h0, rr[k]}, {30'h0, r});
            rd(ra[k]);
            chk("rdata", rx[k], v);
            chk("rresp", {30'h0, rr[k]}, {30'h0, r});
        end
        $display("test register rows done");
        wr(OFF_LOAD_A, 32'h5);
        wr(OFF_CTL, 32'h21);
        measure(60);
        chk("pulses", 32'd10, pulses);
        chk("double", 32'd0, dbl);
        chk("starts", pulses, starts - s0);
        @(posedge aclk);
        src_sel <= 1'b0;
        measure(60);
        chk("starts unselected", 32'd0, starts - s0);
        src_sel <= 1'b1;
        conv_on <= 1'b0;
        measure(60);
        chk("starts converter off", 32'd0, starts - s0);
        conv_on <= 1'b1;
        wr(OFF_CTL, 32'h01);
        measure(60);
        chk("pulses off", 32'd0, pulses);
        wr(OFF_CTL, 32'h20);
        measure(60);
        chk("pulses disabled", 32'd0, pulses);
        $display("test trigger done");
        wr(OFF_CTL, 32'h23);
        measure(60);
        chk("freeze no halt", 32'd10, pulses);
        halt_req <= 1'b1;
        cyc(4);
        measure(60);
        chk("freeze halted", 32'd0, pulses);
        wr(OFF_CTL, 32'h21);
        measure(60);
        chk("halted no freeze", 32'd10, pulses);
        halt_req <= 1'b0;
        $display("test freeze a done");
        wr(OFF_CTL, 32'h0);
        cyc(4);
        p = pwm_a;
        wr(OFF_CTL, 32'h40);
        cyc(2);
        chk("pwm inverted", {31'h0, ~p}, {31'h0, pwm_a});
        wr(OFF_CTL, 32'h0);
        cyc(2);
        chk("pwm plain", {31'h0, p}, {31'h0, pwm_a});
        $display("test pwm done");
        for (int k = 0; k < 4; k++) begin
            wr(OFF_CTL, 32'h101 | (32'(k) << 2) | (32'(k) << 10));
            rd(OFF_EVT_A);
            e_a = v;
            rd(OFF_EVT_B);
            e_b = v;
            cap_a <= 1'b1;
            cap_b <= 1'b1;
            cyc(5);
            cap_a <= 1'b0;
            cap_b <= 1'b0;
            cyc(5);
            rd(OFF_EVT_A);
            chk("events_a", (e_a + dexp[k]) & HALF16_MASK, v);
            rd(OFF_EVT_B);
            chk("events_b", (e_b + dexp[k]) & HALF16_MASK, v);
        end
        $display("test edges done");
        wr(OFF_CTL, 32'h100);
        same_twice(OFF_CNT_B, 1'b0, "count_b running");
        wr(OFF_CTL, 32'h0);
        rd(OFF_CNT_B);
        chk("count_b held", 32'habcd, v);
        wr(OFF_CTL, 32'h300);
        same_twice(OFF_CNT_B, 1'b0, "count_b no halt");
        halt_req <= 1'b1;
        cyc(4);
        same_twice(OFF_CNT_B, 1'b1, "count_b frozen");
        halt_req <= 1'b0;
        $display("test half b done");
        wr(OFF_CFG, 32'h1);
        wr(OFF_CTL, 32'h10);
        same_twice(OFF_RTC, 1'b0, "calendar on");
        // same gap twice, the second with the clock enable low for 20 edges
        rd(OFF_RTC);
        w = v;
        cyc(20);
        rd(OFF_RTC);
        e_a = v - w;
        rd(OFF_RTC);
        w = v;
        ce <= 1'b0;
        cyc(20);
        ce <= 1'b1;
        rd(OFF_RTC);
        chk("clock enable hold", e_a - 32'd20, v - w);
        wr(OFF_CTL, 32'h0);
        same_twice(OFF_RTC, 1'b1, "calendar off");
        wr(OFF_CFG, 32'h0);
        wr(OFF_CTL, 32'h121);
        measure(60);
        chk("pulses 32-bit", 32'd10, pulses);
        same_twice(OFF_CNT_B, 1'b1, "count_b unused");
        $display("test arrangements done");
        @(posedge aclk);
        aresetn <= 1'b0;
        cyc(3);
        aresetn <= 1'b1;
        rd(OFF_CTL);
        chk("ctl reset", CTL_RESET, v);
        rd(OFF_CFG);
        chk("cfg reset", 32'h0, v);
        rd(OFF_LOAD_A);
        chk("load_a reset", LOAD_RESET, v);
        measure(20);
        chk("pulses reset", 32'd0, pulses);
        $display("test reset done");
        summarize();
    end
endmodule : tb_timer_control_register
